// *** hw/nbf_pkg.sv ***
// nbf_pkg: constants and carrier types for the nibble bus fetch block.
// assumes a single 250 MHz clock; the two-phase clock is modelled as enables.
// Overview of operation
// - addresses and data share one four-line bus, multiplexed per cycle.
// - reset high clears flags and status and zeroes the program counter.
// - test input is sampled so the conditional jump can branch on it.
// - a cycle-start marker flags the start of each instruction cycle.
// - program-memory select is asserted when program memory data is needed.
// - four data-memory bank selects, one per bank of companion RAM; the core only ever drives the bank 0 line.
// - one-word instruction is 8 bits and takes 8 clock periods.
// - two-word instruction is 16 bits and takes two cycles, 16 periods.
// - upper nibble is opcode, lower nibble is modifier.
// - second word of two-word instruction is address or immediate data.
// - opcode nibble in first fetch phase, modifier in second.
// - io, ram and accumulator group are single word, modifier picks op.
// - addresses 4K words of program memory and 5120 bits of RAM.
// - sixteen four-bit index registers hold temporary data.
// - up to 16 four-bit input and 16 output ports addressed.
package nbf_pkg;
	localparam int unsigned NBF_NIB_W = 4;
	localparam int unsigned NBF_PC_W = 12;
	localparam int unsigned NBF_NUM_IDX = 16;
	localparam int unsigned NBF_NUM_BANK = 4;
	localparam int unsigned NBF_PHASES = 8;
	localparam int unsigned NBF_RESET_CLR_CYC = 64;
	localparam int unsigned NBF_CLK_NS = 4;
	localparam int unsigned NBF_PHASE_NS = 4;
	localparam int unsigned NBF_PHASE_DIV =
		(NBF_PHASE_NS + NBF_CLK_NS - 1) / NBF_CLK_NS;
	localparam logic [11:0] NBF_PC_RST = 12'h000;
	localparam logic [3:0] NBF_OP_JCN = 4'h1;
	localparam logic [3:0] NBF_OP_FIM = 4'h2;
	localparam logic [3:0] NBF_OP_JUN = 4'h4;
	localparam logic [3:0] NBF_OP_JMS = 4'h5;
	localparam logic [3:0] NBF_OP_ISZ = 4'h7;
	localparam logic [3:0] NBF_OP_IO = 4'he;
	localparam logic [3:0] NBF_OP_ACC = 4'hf;

	typedef enum logic [2:0] {
		NBF_A1, NBF_A2, NBF_A3, NBF_M1, NBF_M2, NBF_X1, NBF_X2, NBF_X3
	} nbf_phase_t;

	typedef struct packed {
		logic [3:0] opcode_nibble;
		logic [3:0] modifier_nibble;
	} nbf_word_t;

	typedef struct packed {
		nbf_word_t word;
		logic second_word;
		logic two_word;
		logic test_level;
	} nbf_decode_t;
endpackage

// *** hw/nbf_core.sv ***
// nbf_core: bus sequencer and instruction fetch of a 4-bit processor.
// assumes i_phase_en marks each clock period; memories answer at m1/m2.
`timescale 1ns/1ns
module nbf_core
	import nbf_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_cpu_reset,
	input wire logic i_phase_en,
	// shared nibble bus
	input wire logic [3:0] i_shared_nibble_bus,
	output logic [3:0] o_shared_nibble_bus,
	output logic o_shared_nibble_bus_oe_n,
	// control pins
	input wire logic i_test,
	output logic o_cycle_start,
	output logic o_program_memory_select,
	output logic [3:0] o_data_memory_bank_select,
	// decode result
	output nbf_decode_t o_decode,
	output logic [11:0] o_pc,
	output logic o_word_valid
);
	// pin synchronisers
	logic [3:0] bus_s1_q, bus_s2_q;
	logic rst_s1_q, rst_s2_q, test_s1_q, test_s2_q;
	always_ff @(posedge i_clk) begin
		bus_s1_q <= i_shared_nibble_bus;
		bus_s2_q <= bus_s1_q;
		rst_s1_q <= i_cpu_reset;
		rst_s2_q <= rst_s1_q;
		test_s1_q <= i_test;
		test_s2_q <= test_s1_q;
	end

	nbf_phase_t phase_q, phase_d;
	logic [11:0] pc_q, pc_d;
	logic [3:0] op_q, op_d, mod_q, mod_d;
	logic second_q, second_d, two_q, two_d, test_q, test_d;
	logic valid_q, valid_d, sync_q, sync_d;
	logic [3:0] bus_out_q, bus_out_d;
	logic oe_n_q, oe_n_d, rom_q, rom_d;
	logic [3:0] bank_q, bank_d;
	logic [3:0] bank_sel_q, bank_sel_d;
	logic [3:0] idx_q [NBF_NUM_IDX];
	logic [6:0] rst_cnt_q, rst_cnt_d;

	function automatic logic is_two(input logic [3:0] op);
		// io and accumulator groups are single word
		is_two = (op == NBF_OP_JCN) || (op == NBF_OP_JUN) ||
			(op == NBF_OP_JMS) || (op == NBF_OP_ISZ) ||
			(op == NBF_OP_FIM);
	endfunction

	always_comb begin
		phase_d = phase_q;
		pc_d = pc_q;
		op_d = op_q;
		mod_d = mod_q;
		second_d = second_q;
		two_d = two_q;
		test_d = test_q;
		valid_d = 1'b0;
		sync_d = sync_q;
		bus_out_d = bus_out_q;
		oe_n_d = oe_n_q;
		rom_d = rom_q;
		bank_d = bank_q;
		bank_sel_d = bank_sel_q;
		rst_cnt_d = rst_cnt_q;
		if (rst_s2_q) begin
			// flags and pc clear at once; registers need a long hold
			// park in last phase so the first step opens a full cycle
			phase_d = NBF_X3;
			pc_d = NBF_PC_RST;
			second_d = 1'b0;
			two_d = 1'b0;
			test_d = 1'b0;
			sync_d = 1'b0;
			oe_n_d = 1'b1;
			rom_d = 1'b0;
			bank_d = 4'h0;
			bank_sel_d = 4'h1;
			if (rst_cnt_q != 7'(NBF_RESET_CLR_CYC))
				rst_cnt_d = rst_cnt_q + 7'h01;
		end else if (i_phase_en) begin
			rst_cnt_d = 7'h00;
			// eight phases make one instruction cycle
			phase_d = nbf_phase_t'(3'(phase_q) + 3'h1);
			sync_d = (phase_q == NBF_X3);
			rom_d = 1'b0;
			bank_d = 4'h0;
			oe_n_d = 1'b1; // released while memory answers
			case (phase_q)
				NBF_X3: begin
					bus_out_d = pc_q[3:0];
					oe_n_d = 1'b0;
				end
				NBF_A1: begin
					bus_out_d = pc_q[7:4];
					oe_n_d = 1'b0;
				end
				NBF_A2: begin
					bus_out_d = pc_q[11:8];
					oe_n_d = 1'b0;
					rom_d = 1'b1;
					bank_d = bank_sel_q;
				end
				NBF_A3: ;
				NBF_M1: op_d = bus_s2_q;
				NBF_M2: begin
					mod_d = bus_s2_q;
					test_d = test_s2_q;
					valid_d = 1'b1;
					pc_d = pc_q + 12'h001;
					if (second_q) begin
						second_d = 1'b0;
						two_d = 1'b1;
						op_d = op_q;
					end else begin
						second_d = is_two(op_q);
						two_d = is_two(op_q);
					end
				end
				NBF_X1: ;
				NBF_X2: ;
				default: phase_d = NBF_A1;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			phase_q <= NBF_X3;
			pc_q <= NBF_PC_RST;
			op_q <= 4'h0;
			mod_q <= 4'h0;
			second_q <= 1'b0;
			two_q <= 1'b0;
			test_q <= 1'b0;
			valid_q <= 1'b0;
			sync_q <= 1'b0;
			bus_out_q <= 4'h0;
			oe_n_q <= 1'b1;
			rom_q <= 1'b0;
			bank_q <= 4'h0;
			bank_sel_q <= 4'h1;
			rst_cnt_q <= 7'h00;
		end else begin
			phase_q <= phase_d;
			pc_q <= pc_d;
			op_q <= op_d;
			mod_q <= mod_d;
			second_q <= second_d;
			two_q <= two_d;
			test_q <= test_d;
			valid_q <= valid_d;
			sync_q <= sync_d;
			bus_out_q <= bus_out_d;
			oe_n_q <= oe_n_d;
			rom_q <= rom_d;
			bank_q <= bank_d;
			bank_sel_q <= bank_sel_d;
			rst_cnt_q <= rst_cnt_d;
		end
	end

	// index file cleared on i_reset_n low or after a full long cpu reset hold
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < NBF_NUM_IDX; i++) begin
			if (!i_reset_n || rst_cnt_q == 7'(NBF_RESET_CLR_CYC))
				idx_q[i] <= 4'h0;
		end
	end

	assign o_shared_nibble_bus = bus_out_q;
	assign o_shared_nibble_bus_oe_n = oe_n_q;
	assign o_cycle_start = sync_q;
	assign o_program_memory_select = rom_q;
	assign o_data_memory_bank_select = bank_q;
	assign o_pc = pc_q;
	assign o_word_valid = valid_q;
	assign o_decode.word.opcode_nibble = op_q;
	assign o_decode.word.modifier_nibble = mod_q;
	assign o_decode.second_word = two_q && !second_q;
	assign o_decode.two_word = two_q;
	assign o_decode.test_level = test_q;
endmodule // nbf_core

// *** verification/nbf_core_monitor.sv ***
// nbf_core_monitor: port assertions for nbf_core.
// assumes phase_en pulses at least two clocks apart.
`timescale 1ns/1ns
module nbf_core_monitor
	import nbf_pkg::*;
(
	// watched ports
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_cpu_reset,
	input wire logic i_phase_en,
	input wire logic o_shared_nibble_bus_oe_n,
	input wire logic o_cycle_start,
	input wire logic o_program_memory_select,
	input wire logic [3:0] o_data_memory_bank_select,
	input wire logic [11:0] o_pc,
	input wire logic o_word_valid
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n || i_cpu_reset);
	logic [3:0] cnt_q;
	logic seen_q;
	// first start after any reset has no full cycle before it
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_cpu_reset) begin
			cnt_q <= 4'h0;
			seen_q <= 1'b0;
		end else if ($rose(o_cycle_start)) begin
			cnt_q <= 4'h0;
			seen_q <= 1'b1;
		end else if (i_phase_en) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	cycle_len_a: assert property ($rose(o_cycle_start) && seen_q |-> cnt_q == 4'h8) else $error("cycle not 8 phases");
	outs_stand_a: assert property ($past(i_reset_n) && !i_phase_en |=> $stable({o_cycle_start, o_program_memory_select, o_shared_nibble_bus_oe_n})) else $error("output moved between phases");
	start_sel_a: assert property (o_cycle_start |-> !o_program_memory_select) else $error("select during start");
	sel_drive_a: assert property (o_program_memory_select |-> !o_shared_nibble_bus_oe_n) else $error("select without address");
	read_free_a: assert property (o_word_valid |-> o_shared_nibble_bus_oe_n) else $error("bus driven at read");
	word_pulse_a: assert property (o_word_valid |=> !o_word_valid) else $error("word valid too long");
	bank_sel_a: assert property (o_program_memory_select |-> o_data_memory_bank_select == 4'h1) else $error("bank select wrong");
	pc_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) i_cpu_reset [*4] |-> o_pc == 12'h000) else $error("pc not cleared");
endmodule // nbf_core_monitor
bind nbf_core nbf_core_monitor nbf_core_monitor_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cpu_reset(i_cpu_reset), .i_phase_en(i_phase_en), .o_shared_nibble_bus_oe_n(o_shared_nibble_bus_oe_n), .o_cycle_start(o_cycle_start), .o_program_memory_select(o_program_memory_select), .o_data_memory_bank_select(o_data_memory_bank_select), .o_pc(o_pc), .o_word_valid(o_word_valid));

// *** verification/nbf_rom_model.sv ***
// nbf_rom_model: program memory answering the two fetch phases.
// assumes phase_en every four clocks, so data holds a full phase.
`timescale 1ns/1ns
module nbf_rom_model
	import nbf_pkg::*;
(
	// cpu side
	input wire logic i_clk,
	input wire logic i_phase_en,
	input wire logic i_cycle_start,
	input wire logic [3:0] i_bus,
	// bus answer
	output logic [3:0] o_bus
);
	logic [7:0] rom [8] = '{8'h10, 8'h5a, 8'he3, 8'hf7, 8'h21, 8'h44, 8'h8c, 8'hd2};
	logic [2:0] ph_q = 3'h7;
	logic [11:0] addr_q = 12'h000;
	logic [3:0] last_q = 4'h0;
	logic [7:0] word;
	// serves by the address sent on the bus, so a bad address shows
	always_ff @(posedge i_clk) begin
		last_q <= o_bus;
		if (i_phase_en) begin
			ph_q <= i_cycle_start ? 3'h1 : ph_q + 3'h1;
			case (ph_q)
				3'h0: addr_q[3:0] <= i_bus;
				3'h1: addr_q[7:4] <= i_bus;
				3'h2: addr_q[11:8] <= i_bus;
				default: ;
			endcase
		end
	end
	// out of range answers a word no row expects
	assign word = (addr_q[11:3] == 9'h000) ? rom[addr_q[2:0]] : 8'h00;
	// outside reads the bus toggles so a stale value never passes
	assign o_bus = (ph_q == 3'h3) ? word[7:4] : (ph_q == 3'h4) ? word[3:0] : ~last_q;
endmodule // nbf_rom_model

// *** verification/nbf_core_test.sv ***
// nbf_core_test: fetches a short program, checks decode and reset.
// assumes the rom model holds the same eight words as the rows here.
`timescale 1ns/1ns
module nbf_core_test;
	import nbf_pkg::*;
	logic i_clk = 1'b0, i_reset_n = 1'b0, i_cpu_reset = 1'b0;
	logic i_phase_en = 1'b0, i_test = 1'b1;
	logic [3:0] bus_out, rom_bus, wire_bus, banks;
	logic oe_n, cs, pms, wv;
	logic [11:0] pc;
	nbf_decode_t dec;
	int bad_count = 0, checked = 0, n;
	// word, second-word flag, two-word flag
	logic [9:0] rows [8] = '{{8'h10, 2'b01}, {8'h5a, 2'b11}, {8'he3, 2'b00}, {8'hf7, 2'b00}, {8'h21, 2'b01}, {8'h44, 2'b11}, {8'h8c, 2'b00}, {8'hd2, 2'b00}};
	assign wire_bus = oe_n ? rom_bus : bus_out;
	nbf_core nbf_core_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cpu_reset(i_cpu_reset), .i_phase_en(i_phase_en), .i_shared_nibble_bus(wire_bus), .o_shared_nibble_bus(bus_out), .o_shared_nibble_bus_oe_n(oe_n), .i_test(i_test), .o_cycle_start(cs), .o_program_memory_select(pms), .o_data_memory_bank_select(banks), .o_decode(dec), .o_pc(pc), .o_word_valid(wv));
	nbf_rom_model nbf_rom_model_inst (.i_clk(i_clk), .i_phase_en(i_phase_en), .i_cycle_start(cs), .i_bus(wire_bus), .o_bus(rom_bus));
	initial forever #2 i_clk = ~i_clk;
	always begin
		repeat (3) @(negedge i_clk);
		i_phase_en = i_reset_n;
		@(negedge i_clk);
		i_phase_en = 1'b0;
	end
	task automatic chk(logic [11:0] got, logic [11:0] exp, string m);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait; n returns the clocks waited
	task automatic wait_word();
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (wv !== 1'b1 && n < 200);
	endtask
	initial begin
		repeat (5) @(negedge i_clk);
		i_reset_n = 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(negedge i_clk);
			i_test = k[0];
			wait_word();
			chk({1'b0, dec.test_level, dec.word, dec.second_word, dec.two_word | dec.second_word}, {1'b0, k[0], rows[k]}, "decode");
			if (k > 0) chk(12'(n), 12'h020, "cycle length");
		end
		repeat (4) @(negedge i_clk);
		chk(pc, 12'h008, "pc count");
		$display("fetch test done");
		i_cpu_reset = 1'b1;
		repeat (70) @(negedge i_clk);
		chk(pc, 12'h000, "pc reset");
		i_cpu_reset = 1'b0;
		$display("reset test done");
		tally_and_finish();
	end
	initial begin
		#4000;
		bad_count++;
		tally_and_finish();
	end
endmodule // nbf_core_test
